// File: verilog/nvt_trap_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: Redirect enable at bit 45; when clear, nesting controls act as basic.
// RULE2: Redirect on: register accesses become memory ops; hyp regs alias kernel regs.
// RULE3: Redirect on: kernel-to-kernel exception saves mode bits 3:2 as 10.
// RULE4: Primary nesting clear forces redirect enable to read as inactive; here only the status word shows it off, the config word reads back the raw bit.
// RULE5: Fields have no defined warm-reset value; cleared here.
// RULE6: Translation trap bit 44 traps kernel stage-1 translations, syndrome 0x18.
// RULE7: Secondary clear, redirect and primary set: hyp/cross/host regs transform.
// RULE8: Primary and secondary both clear, without redirect, cause no nesting trap.
// RULE9: Secondary set with redirect: hyp-level register accesses transform.
// RULE10: Secondary set, no redirect: vector/link/saved/context regs trap 0x18.
// RULE11: With redirect, transformation beats nesting-control traps.
// RULE12: Traps from other control bits beat transformation.
// RULE13: Unimplemented affected register is undefined, not trapped or transformed.
// RULE14: Secondary clear, primary set: kernel-to-kernel exception saves mode 10.
// RULE15: Both nesting set: descriptor bit54 privileged XN, bit53 zero, bit6 zero.
// RULE16: Both set, hierarchical on: table bit61 zero, bit60 priv XN, bit59 zero.
// RULE17: Both set at kernel level: privileged-access-never acts as zero.
// RULE18: Both set at kernel level: unprivileged loads/stores act as ordinary.
// RULE19: Secondary set, primary clear: one of three fixed behaviours.
// RULE20: Secondary nesting value may be cached in translation entries.
// RULE21: Primary nesting bit 42 without redirect traps hyp accesses, 0x18.
// RULE22: Field of an absent feature reads zero and ignores writes.
module nvt_trap_ctrl
  import nvt_pkg::*;
#(
  parameter bit       HAS_BASIC   = 1'b1,
  parameter bit       HAS_ENH     = 1'b1,
  parameter bit       HAS_CTX_NUM = 1'b1,
  parameter nvt_mix_t MIX         = NVT_MIX_PER_BIT
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic      [1:0]  hresp,
  input  wire logic        req_valid,
  input  wire logic        req_at_kernel,
  input  wire logic        req_hyp_enabled,
  input  wire nvt_regcls_t req_cls,
  input  wire logic        req_implemented,
  input  wire logic        req_is_xlat,
  input  wire logic        req_other_trap,
  output logic             rsp_valid,
  output logic             rsp_trap,
  output logic      [5:0]  rsp_syndrome,
  output logic             rsp_transform,
  output logic             rsp_redirect,
  output logic             rsp_undef,
  output logic             rsp_other_trap,
  input  wire logic        exc_valid,
  input  wire logic        exc_kernel_to_kernel,
  output logic             mode_valid,
  output logic      [1:0]  saved_mode_hi,
  input  wire logic        desc_valid,
  input  wire logic        desc_is_table,
  input  wire logic        desc_hier_en,
  input  wire logic [63:0] desc_in,
  output logic             desc_out_valid,
  output logic      [63:0] desc_out,
  output logic             desc_priv_xn,
  input  wire logic        pan_in,
  input  wire logic        exec_at_kernel,
  output logic             pan_eff,
  output logic             unpriv_as_plain,
  output logic             tlb_secondary_tag
);

  nvt_ctrl_if ctl ();

  nvt_eff_decode #(
    .HAS_ENH (HAS_ENH),
    .MIX     (MIX)
  ) u_dec (
    .ctl (ctl)
  );

  logic        cfg_mre_reg;
  logic        cfg_att_reg;
  logic        cfg_sec_reg;
  logic        cfg_pri_reg;
  logic        wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic        addr_ok;
  logic        both_set;
  logic        req_nest;
  logic        trap_next;
  logic        xform_next;
  logic        redir_next;
  logic        undef_next;
  logic        other_next;

  assign ctl.pri = cfg_pri_reg;
  assign ctl.sec = cfg_sec_reg;
  assign ctl.mre = cfg_mre_reg;
  assign ctl.att = cfg_att_reg;
  assign both_set = ctl.pri_eff & ctl.sec_eff;

  function automatic logic hyp_group(input nvt_regcls_t c);
    return (c == NVT_CLS_HYP) || (c == NVT_CLS_HYP_ALIAS) ||
           (c == NVT_CLS_CROSS) || (c == NVT_CLS_HOSTUSER);
  endfunction

  function automatic logic hyp_only(input nvt_regcls_t c);
    return (c == NVT_CLS_HYP) || (c == NVT_CLS_HYP_ALIAS);
  endfunction

  function automatic logic core_group(input nvt_regcls_t c);
    return (c == NVT_CLS_KERNEL_CORE) || ((c == NVT_CLS_CTXNUM) && HAS_CTX_NUM);
  endfunction

  // Bus slave: zero wait states, OKAY always
  assign addr_ok = hsel & hready & htrans[1];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= NVT_OFF_CFG_LO;
    end else if (addr_ok) begin
      wr_pend_reg <= hwrite;
      wr_addr_reg <= haddr;
    end else if (hready) begin
      wr_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b0;
      hresp     <= NVT_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= NVT_HRESP_OKAY;
    end
  end

  // Warm reset leaves these undefined; a zero is one legal pick
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_mre_reg <= NVT_FIELD_RST; // RULE5
      cfg_att_reg <= NVT_FIELD_RST;
      cfg_sec_reg <= NVT_FIELD_RST;
      cfg_pri_reg <= NVT_FIELD_RST;
    end else if (wr_pend_reg && (wr_addr_reg == NVT_OFF_CFG_HI)) begin
      cfg_mre_reg <= HAS_ENH & hwdata[NVT_HI_MRE]; // RULE22
      cfg_att_reg <= HAS_BASIC & hwdata[NVT_HI_ATT];
      cfg_sec_reg <= HAS_BASIC & hwdata[NVT_HI_SEC];
      cfg_pri_reg <= HAS_BASIC & hwdata[NVT_HI_PRI]; // RULE22
    end
  end

  // Raw field readback at the config word; the status word reads the effective values
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= '0;
    end else if (addr_ok && !hwrite) begin
      hrdata <= '0;
      case (haddr)
        NVT_OFF_CFG_HI: begin
          hrdata[NVT_HI_MRE] <= cfg_mre_reg; // RULE4
          hrdata[NVT_HI_ATT] <= cfg_att_reg;
          hrdata[NVT_HI_SEC] <= cfg_sec_reg;
          hrdata[NVT_HI_PRI] <= cfg_pri_reg;
        end
        NVT_OFF_STATUS: begin
          hrdata[NVT_ST_PRI] <= ctl.pri_eff;
          hrdata[NVT_ST_SEC] <= ctl.sec_eff;
          hrdata[NVT_ST_MRE] <= ctl.mre_eff;
          hrdata[NVT_ST_ATT] <= ctl.att_eff;
          hrdata[NVT_ST_FNV] <= HAS_BASIC;
          hrdata[NVT_ST_FN2] <= HAS_ENH;
        end
        default: begin
          hrdata <= '0;
        end
      endcase
    end
  end

  // Register access and translation instruction verdict
  assign req_nest = req_valid & req_at_kernel & req_hyp_enabled;

  always_comb begin
    trap_next  = 1'b0;
    xform_next = 1'b0;
    redir_next = 1'b0;
    undef_next = 1'b0;
    other_next = 1'b0;
    if (req_nest && req_is_xlat) begin
      other_next = req_other_trap;
      trap_next  = !req_other_trap && ctl.att_eff; // RULE6
    end else if (req_nest && req_cls != NVT_CLS_NONE) begin
      if (!req_implemented) begin
        undef_next = 1'b1; // RULE13
      end else if (req_other_trap) begin
        other_next = 1'b1; // RULE12
      end else if (ctl.mre_eff) begin
        // Transformation wins over nesting traps
        if (ctl.sec_eff) begin
          xform_next = hyp_only(req_cls); // RULE9
        end else begin
          xform_next = hyp_group(req_cls); // RULE7
        end
        redir_next = xform_next && (req_cls == NVT_CLS_HYP_ALIAS); // RULE2
      end else begin // RULE1 RULE8
        trap_next = (ctl.pri_eff && hyp_group(req_cls)) || // RULE21
                    (ctl.sec_eff && core_group(req_cls)); // RULE10
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rsp_valid      <= 1'b0;
      rsp_trap       <= 1'b0;
      rsp_syndrome   <= '0;
      rsp_transform  <= 1'b0;
      rsp_redirect   <= 1'b0;
      rsp_undef      <= 1'b0;
      rsp_other_trap <= 1'b0;
    end else begin
      rsp_valid      <= req_valid;
      rsp_trap       <= trap_next;
      rsp_syndrome   <= trap_next ? NVT_SYN_NEST : '0;
      rsp_transform  <= xform_next; // RULE11
      rsp_redirect   <= redir_next;
      rsp_undef      <= undef_next;
      rsp_other_trap <= other_next;
    end
  end

  // Saved mode bits for exceptions taken to the kernel level
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode_valid    <= 1'b0;
      saved_mode_hi <= NVT_MODE_PLAIN;
    end else begin
      mode_valid <= exc_valid;
      if (exc_valid) begin
        if (exc_kernel_to_kernel && (ctl.mre_eff || (ctl.pri_eff && !ctl.sec_eff))) begin
          saved_mode_hi <= NVT_MODE_NEST; // RULE3 RULE14
        end else begin
          saved_mode_hi <= NVT_MODE_PLAIN;
        end
      end
    end
  end

  // Descriptor bit reinterpretation
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      desc_out_valid <= 1'b0;
      desc_out       <= '0;
      desc_priv_xn   <= 1'b0;
    end else begin
      desc_out_valid <= desc_valid;
      if (desc_valid) begin
        desc_out     <= desc_in;
        desc_priv_xn <= 1'b0;
        if (both_set && !desc_is_table) begin
          desc_out[NVT_D_R53] <= 1'b0; // RULE15
          desc_out[NVT_D_B6]  <= 1'b0;
          desc_priv_xn        <= desc_in[NVT_D_PRX];
        end else if (both_set && desc_hier_en) begin
          desc_out[NVT_T_B61] <= 1'b0; // RULE16
          desc_out[NVT_T_R59] <= 1'b0;
          desc_priv_xn        <= desc_in[NVT_T_PRXT];
        end
      end
    end
  end

  // Kernel-level state overrides and translation entry tag
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pan_eff           <= 1'b0;
      unpriv_as_plain   <= 1'b0;
      tlb_secondary_tag <= 1'b0;
    end else begin
      pan_eff           <= pan_in && !(both_set && exec_at_kernel); // RULE17
      unpriv_as_plain   <= both_set && exec_at_kernel; // RULE18
      tlb_secondary_tag <= ctl.sec_eff; // RULE20
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_xlat_trap;
    req_nest && req_is_xlat && ctl.att_eff && !req_other_trap
      |=> rsp_trap && rsp_syndrome == NVT_SYN_NEST;
  endproperty
  a_xlat_trap: assert property (p_xlat_trap) else $error("translation trap missing"); // RULE6

  property p_xlat_quiet;
    req_valid && req_is_xlat && !ctl.att_eff |=> !rsp_trap;
  endproperty
  a_xlat_quiet: assert property (p_xlat_quiet) else $error("translation trap while off"); // RULE6

  property p_mre_gate;
    !cfg_pri_reg |-> !ctl.mre_eff;
  endproperty
  a_mre_gate: assert property (p_mre_gate) else $error("redirect active without primary"); // RULE4

  property p_mode_nest;
    exc_valid && exc_kernel_to_kernel && ctl.mre_eff
      |=> saved_mode_hi == NVT_MODE_NEST && mode_valid;
  endproperty
  a_mode_nest: assert property (p_mode_nest) else $error("saved mode not 10"); // RULE3

  property p_mode_sec;
    exc_valid && exc_kernel_to_kernel && ctl.pri_eff && !ctl.sec_eff
      |=> saved_mode_hi == NVT_MODE_NEST;
  endproperty
  a_mode_sec: assert property (p_mode_sec) else $error("saved mode not 10 under nesting"); // RULE14

  property p_xform_excl;
    rsp_transform |-> !rsp_trap && !rsp_undef && $past(ctl.mre_eff);
  endproperty
  a_xform_excl: assert property (p_xform_excl) else $error("transform clashes with trap"); // RULE11

  property p_other_first;
    req_nest && req_other_trap && req_implemented && (req_is_xlat || req_cls != NVT_CLS_NONE)
      |=> !rsp_transform && rsp_other_trap;
  endproperty
  a_other_first: assert property (p_other_first) else $error("other trap lost"); // RULE12

  property p_undef;
    req_nest && !req_is_xlat && req_cls != NVT_CLS_NONE && !req_implemented
      |=> rsp_undef && !rsp_trap && !rsp_transform;
  endproperty
  a_undef: assert property (p_undef) else $error("absent register not undefined"); // RULE13

  property p_sec_quiet;
    req_valid && !ctl.pri_eff && !ctl.sec_eff |=> !rsp_trap || $past(req_is_xlat);
  endproperty
  a_sec_quiet: assert property (p_sec_quiet) else $error("nesting trap while clear"); // RULE8

  property p_desc;
    desc_valid && both_set && !desc_is_table
      |=> !desc_out[53] && !desc_out[6] && desc_priv_xn == $past(desc_in[54]);
  endproperty
  a_desc: assert property (p_desc) else $error("descriptor bits not rewritten"); // RULE15

  property p_pan;
    both_set && exec_at_kernel |=> !pan_eff && unpriv_as_plain;
  endproperty
  a_pan: assert property (p_pan) else $error("kernel overrides not applied"); // RULE17

endmodule

// File: verilog/nvt_pkg.sv
package nvt_pkg;

  localparam logic [31:0] NVT_OFF_CFG_LO = 32'h0000_0000;
  localparam logic [31:0] NVT_OFF_CFG_HI = 32'h0000_0004;
  localparam logic [31:0] NVT_OFF_STATUS = 32'h0000_0008;

  // Field positions within the high word (bit n of the 64-bit register is n-32)
  localparam int NVT_HI_MRE = 45 - 32;
  localparam int NVT_HI_ATT = 44 - 32;
  localparam int NVT_HI_SEC = 43 - 32;
  localparam int NVT_HI_PRI = 42 - 32;

  localparam int NVT_ST_PRI = 0;
  localparam int NVT_ST_SEC = 1;
  localparam int NVT_ST_MRE = 2;
  localparam int NVT_ST_ATT = 3;
  localparam int NVT_ST_FNV = 4;
  localparam int NVT_ST_FN2 = 5;

  localparam logic [5:0] NVT_SYN_NEST   = 6'h18;
  localparam logic [1:0] NVT_MODE_NEST  = 2'h2;
  localparam logic [1:0] NVT_MODE_PLAIN = 2'h1;
  localparam logic [1:0] NVT_HRESP_OKAY = 2'h0;
  localparam logic       NVT_FIELD_RST  = 1'h0;

  localparam int NVT_D_PRX  = 54;
  localparam int NVT_D_R53  = 53;
  localparam int NVT_D_B6   = 6;
  localparam int NVT_T_B61  = 61;
  localparam int NVT_T_PRXT = 60;
  localparam int NVT_T_R59  = 59;

  typedef enum logic [2:0] {
    NVT_CLS_NONE,
    NVT_CLS_HYP,
    NVT_CLS_HYP_ALIAS,
    NVT_CLS_CROSS,
    NVT_CLS_HOSTUSER,
    NVT_CLS_KERNEL_CORE,
    NVT_CLS_CTXNUM
  } nvt_regcls_t;

  typedef enum logic [1:0] {
    NVT_MIX_AS_BOTH_SET,
    NVT_MIX_AS_BOTH_CLEAR,
    NVT_MIX_PER_BIT
  } nvt_mix_t;

endpackage

// File: verilog/nvt_ctrl_if.sv
`timescale 1ns/1ps
interface nvt_ctrl_if;
  logic pri;
  logic sec;
  logic mre;
  logic att;
  logic pri_eff;
  logic sec_eff;
  logic mre_eff;
  logic att_eff;

  modport src (output pri, sec, mre, att, input pri_eff, sec_eff, mre_eff, att_eff);
  modport dec (input pri, sec, mre, att, output pri_eff, sec_eff, mre_eff, att_eff);
endinterface

// File: verilog/nvt_eff_decode.sv
`timescale 1ns/1ps
module nvt_eff_decode
  import nvt_pkg::*;
#(
  parameter bit       HAS_ENH = 1'b1,
  parameter nvt_mix_t MIX     = NVT_MIX_PER_BIT
) (
  nvt_ctrl_if.dec ctl
);

  logic pri_w;
  logic sec_w;

  // Secondary set without primary: fixed implementation choice
  always_comb begin
    pri_w = ctl.pri;
    sec_w = ctl.sec;
    if (ctl.sec && !ctl.pri) begin
      case (MIX) // RULE19
        NVT_MIX_AS_BOTH_SET: begin
          pri_w = 1'b1;
          sec_w = 1'b1;
        end
        NVT_MIX_AS_BOTH_CLEAR: begin
          pri_w = 1'b0;
          sec_w = 1'b0;
        end
        default: begin
          pri_w = ctl.pri;
          sec_w = ctl.sec;
        end
      endcase
    end
  end

  assign ctl.pri_eff = pri_w;
  assign ctl.sec_eff = sec_w;
  // Redirect enable is dead while primary nesting is off
  assign ctl.mre_eff = HAS_ENH & ctl.mre & ctl.pri; // RULE4
  assign ctl.att_eff = ctl.att;

endmodule

// File: tb/nested_virt_trap_control_bench.sv
`timescale 1ns/1ps
module nested_virt_trap_control_bench
  import nvt_pkg::*;
();
  typedef struct packed {
    logic [3:0]  cfg;
    logic        kern;
    logic        hyp;
    nvt_regcls_t cls;
    logic        impl;
    logic        xlat;
    logic        oth;
    logic [4:0]  exp;
  } nvt_row_t;

  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire         hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [1:0]  hresp;
  logic        req_valid = 1'b0;
  logic        req_at_kernel = 1'b0;
  logic        req_hyp_enabled = 1'b0;
  nvt_regcls_t req_cls = NVT_CLS_NONE;
  logic        req_implemented = 1'b0;
  logic        req_is_xlat = 1'b0;
  logic        req_other_trap = 1'b0;
  logic        rsp_valid, rsp_trap, rsp_transform, rsp_redirect, rsp_undef, rsp_other_trap;
  logic [5:0]  rsp_syndrome;
  logic        exc_valid = 1'b0;
  logic        exc_kernel_to_kernel = 1'b0;
  logic        mode_valid;
  logic [1:0]  saved_mode_hi;
  logic        desc_valid = 1'b0;
  logic        desc_is_table = 1'b0;
  logic        desc_hier_en = 1'b0;
  logic [63:0] desc_in = 64'h0;
  logic        desc_out_valid, desc_priv_xn;
  logic [63:0] desc_out;
  logic        pan_in = 1'b0;
  logic        exec_at_kernel = 1'b0;
  logic        pan_eff, unpriv_as_plain, tlb_secondary_tag;
  int          failures = 0;
  int          tests_run = 0;
  logic [31:0] rd;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  nvt_trap_ctrl DUT (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .req_valid(req_valid),
    .req_at_kernel(req_at_kernel), .req_hyp_enabled(req_hyp_enabled), .req_cls(req_cls),
    .req_implemented(req_implemented),
    .req_is_xlat(req_is_xlat), .req_other_trap(req_other_trap), .rsp_valid(rsp_valid),
    .rsp_trap(rsp_trap), .rsp_syndrome(rsp_syndrome), .rsp_transform(rsp_transform),
    .rsp_redirect(rsp_redirect), .rsp_undef(rsp_undef), .rsp_other_trap(rsp_other_trap),
    .exc_valid(exc_valid), .exc_kernel_to_kernel(exc_kernel_to_kernel), .mode_valid(mode_valid),
    .saved_mode_hi(saved_mode_hi), .desc_valid(desc_valid), .desc_is_table(desc_is_table),
    .desc_hier_en(desc_hier_en), .desc_in(desc_in), .desc_out_valid(desc_out_valid),
    .desc_out(desc_out), .desc_priv_xn(desc_priv_xn), .pan_in(pan_in),
    .exec_at_kernel(exec_at_kernel), .pan_eff(pan_eff), .unpriv_as_plain(unpriv_as_plain),
    .tlb_secondary_tag(tlb_secondary_tag)
  );

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Config order {redirect, translation trap, secondary, primary}
  nvt_row_t rows [16] = '{
    '{4'h4, 1, 1, NVT_CLS_NONE,      1, 1, 0, 5'h10},
    '{4'h0, 1, 1, NVT_CLS_NONE,      1, 1, 0, 5'h00},
    '{4'h4, 1, 1, NVT_CLS_NONE,      1, 1, 1, 5'h01},
    '{4'h4, 1, 0, NVT_CLS_NONE,      1, 1, 0, 5'h00},
    '{4'h1, 1, 1, NVT_CLS_HYP,       1, 0, 0, 5'h10},
    '{4'h1, 1, 0, NVT_CLS_HYP,       1, 0, 0, 5'h00},
    '{4'h9, 1, 1, NVT_CLS_CROSS,     1, 0, 0, 5'h08},
    '{4'h9, 1, 1, NVT_CLS_HOSTUSER,  1, 0, 0, 5'h08},
    '{4'h9, 1, 1, NVT_CLS_HYP_ALIAS, 1, 0, 0, 5'h0c},
    '{4'hb, 1, 1, NVT_CLS_HYP,       1, 0, 0, 5'h08},
    '{4'h2, 1, 1, NVT_CLS_KERNEL_CORE, 1, 0, 0, 5'h10},
    '{4'h2, 1, 1, NVT_CLS_CTXNUM,    1, 0, 0, 5'h10},
    '{4'h8, 1, 1, NVT_CLS_HYP,       1, 0, 0, 5'h00},
    '{4'h9, 1, 1, NVT_CLS_KERNEL_CORE, 1, 0, 0, 5'h00},
    '{4'h1, 1, 1, NVT_CLS_HYP,       0, 0, 0, 5'h02},
    '{4'h9, 1, 1, NVT_CLS_HYP,       1, 0, 1, 5'h01}
  };
  logic [3:0]  ec [6] = '{4'h9, 4'h1, 4'h3, 4'h0, 4'h8, 4'h9};
  logic        ee [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [1:0]  em [6] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1};
  logic [3:0]  dc [5] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h1};
  logic        dt [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic        dh [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [63:0] di [5] = '{64'hffff_ffff_ffff_ffff, 64'hffbf_ffff_ffff_ffff,
                          64'hffff_ffff_ffff_ffff, 64'hffff_ffff_ffff_ffff,
                          64'hffff_ffff_ffff_ffff};
  logic [63:0] dq [5] = '{64'hffdf_ffff_ffff_ffbf, 64'hff9f_ffff_ffff_ffbf,
                          64'hd7ff_ffff_ffff_ffff, 64'hffff_ffff_ffff_ffff,
                          64'hffff_ffff_ffff_ffff};
  logic        dx [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    // Only the watchdog ends a stalled wait
    do begin @(posedge sys_clk); end while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge sys_clk); end while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [3:0] c);
    bus(1'b1, NVT_OFF_CFG_HI, {18'h0, c, 10'h0}, rd);
  endtask

  initial begin
    #2ms;
    failures++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    chk(hreadyout, 1'b0);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    bus(1'b0, NVT_OFF_CFG_HI, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b1, NVT_OFF_CFG_HI, 32'h0000_3c00, rd);
    bus(1'b0, NVT_OFF_CFG_HI, 32'h0, rd);
    chk(rd, 32'h0000_3c00);
    bus(1'b1, 32'h0000_000c, 32'hffff_ffff, rd);
    bus(1'b0, 32'h0000_000c, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, NVT_OFF_CFG_LO, 32'h0, rd);
    chk({rd, hresp}, 34'h0);
    foreach (rows[i]) begin
      wr(rows[i].cfg);
      req_valid       <= 1'b1;
      req_at_kernel   <= rows[i].kern;
      req_hyp_enabled <= rows[i].hyp;
      req_cls         <= rows[i].cls;
      req_implemented <= rows[i].impl;
      req_is_xlat     <= rows[i].xlat;
      req_other_trap  <= rows[i].oth;
      @(posedge sys_clk);
      req_valid <= 1'b0;
      #1;
      chk({rsp_valid, rsp_trap, rsp_transform, rsp_redirect, rsp_undef, rsp_other_trap},
          {1'b1, rows[i].exp});
      chk(rsp_syndrome, rows[i].exp[4] ? NVT_SYN_NEST : 6'h00);
      @(posedge sys_clk);
    end
    foreach (ec[i]) begin
      wr(ec[i]);
      exc_valid            <= 1'b1;
      exc_kernel_to_kernel <= ee[i];
      @(posedge sys_clk);
      exc_valid <= 1'b0;
      #1;
      chk({mode_valid, saved_mode_hi}, {1'b1, em[i]});
      @(posedge sys_clk);
    end
    foreach (dc[i]) begin
      wr(dc[i]);
      desc_valid    <= 1'b1;
      desc_is_table <= dt[i];
      desc_hier_en  <= dh[i];
      desc_in       <= di[i];
      @(posedge sys_clk);
      desc_valid <= 1'b0;
      #1;
      chk({desc_out_valid, desc_priv_xn}, {1'b1, dx[i]});
      chk(desc_out, dq[i]);
      @(posedge sys_clk);
    end
    pan_in         <= 1'b1;
    exec_at_kernel <= 1'b1;
    wr(4'h3);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({pan_eff, unpriv_as_plain, tlb_secondary_tag}, 3'h3);
    // Secondary set alone under per-bit choice: only the cached tag follows it
    wr(4'h2);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({pan_eff, unpriv_as_plain, tlb_secondary_tag}, 3'h5);
    bus(1'b0, NVT_OFF_STATUS, 32'h0, rd);
    chk(rd, 32'h0000_0032);
    // Redirect without primary: raw bit reads back, effective value stays off
    wr(4'h8);
    bus(1'b0, NVT_OFF_CFG_HI, 32'h0, rd);
    chk(rd, 32'h0000_2000);
    bus(1'b0, NVT_OFF_STATUS, 32'h0, rd);
    chk(rd, 32'h0000_0030);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({hreadyout, saved_mode_hi, tlb_secondary_tag}, 4'h2);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    bus(1'b0, NVT_OFF_CFG_HI, 32'h0, rd);
    chk(rd, 32'h0);
    complete_run();
  end
endmodule
